// ### addr_field16_decoder.sv
/*
 * Decoder and address generator for the 16-bit primary operand field,
 * two generators so a data move resolves both fields in one request.
 * Assumes the pipeline holds the register file snapshot steady in the
 * request cycle and performs the write-back it is handed.
 */
// Operation
// - The 16-bit operand field selects every pointer and stack mode.
// - Outside data moves the field is instruction bits 31 down to 16.
// - A data move has two fields decoded independently, others one.
// - Prefix 00 adds an unsigned 10-bit byte offset, pointer unchanged.
// - Prefix 01 adds the 10-bit offset shifted left by two.
// - Prefix 100 adds a 7-bit offset, then the pointer gains the index.
// - Prefix 101 takes the SP minus a 13-bit magnitude, SP unchanged.
// - Prefix 1100 uses the pointer, then adds an 8-bit amount to it.
// - Prefix 1101 uses the pointer, then subtracts a 1 to 256 amount.
// - Prefix 1110 subtracts a 1 to 256 amount and uses the result.
// - Prefix 1111 adds the index shifted by 0 to 3 to the pointer.
// - The scaled form with a destination writes the address there.
// - Base and destination take 4-bit selectors, the index 2 bits.
// - Modes not valid with the SP as base are flagged unusable.
`timescale 1ns/10ps
`include "addr_map.svh"

module addr_field16_decoder
(
    // Clock and reset.
    input  wire logic                         mclk_i,
    input  wire logic                         rst_b_i,
    // Request from the pipeline.
    input  wire logic                         req_valid_i,
    input  wire logic [31:0]                  instr_word_i,
    input  wire logic                         move_op_i,
    input  wire logic [15:0]                  move_field_i,
    // Address register file snapshot.
    input  wire addr_field16_pkg::areg_file_t areg_i,
    // Results, one entry per field slot.
    output logic                              rsp_valid_o,
    output logic [1:0]                        slot_valid_o,
    output logic [1:0][31:0]                  eff_addr_o,
    output logic [1:0]                        wb_en_o,
    output logic [1:0][3:0]                   wb_idx_o,
    output logic [1:0][31:0]                  wb_val_o,
    output logic [1:0]                        invalid_o
);
    logic [1:0]  slot_live;
    logic [15:0] field0;
    logic [15:0] field1;
    logic [31:0] base0;
    logic [31:0] index0;
    logic [31:0] stack0;
    logic [8:0]  mag0;
    logic [13:0] mag13_0;

    // Slot 0 always carries the field in the upper half of the word.
    assign field0       = instr_word_i[`FLD_INSTR_HI:`FLD_INSTR_LO];
    // Slot 1 is only meaningful for a data move.
    assign field1       = move_field_i;
    assign slot_live[0] = req_valid_i;
    assign slot_live[1] = req_valid_i && move_op_i;

    // One generator per slot; the two never share arithmetic.
    for (genvar s = 0; s < 2; s++)
    begin : gen_slot
        addr_gen_if u_if ();

        addr_gen u_gen
        (
            .g (u_if.gen)
        );

        // Field and register snapshot into this slot's generator.
        assign u_if.field = (s == 0) ? field0 : field1;
        assign u_if.regs  = areg_i;

        // Valid flag per slot, cleared when no request is taken.
        always_ff @(posedge mclk_i or negedge rst_b_i)
        begin
            if (!rst_b_i)
                slot_valid_o[s] <= 1'b0;
            else
                slot_valid_o[s] <= slot_live[s];
        end

        // Registered results; a dead slot never asks for a write-back.
        always_ff @(posedge mclk_i or negedge rst_b_i)
        begin
            if (!rst_b_i)
            begin
                eff_addr_o[s] <= 32'h0;
                wb_en_o[s]    <= 1'b0;
                wb_idx_o[s]   <= 4'h0;
                wb_val_o[s]   <= 32'h0;
                invalid_o[s]  <= 1'b0;
            end
            else
            begin
                eff_addr_o[s] <= u_if.addr;
                wb_en_o[s]    <= u_if.wb_en && slot_live[s];
                wb_idx_o[s]   <= u_if.wb_idx;
                wb_val_o[s]   <= u_if.wb_val;
                invalid_o[s]  <= u_if.invalid && slot_live[s];
            end
        end
    end

    // Response strobe, one cycle after each taken request.
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rsp_valid_o <= 1'b0;
        else
            rsp_valid_o <= req_valid_i;
    end

    // Helper view of slot 0 for the checks below only.
    assign base0   = areg_i[field0[`BASE_HI:`BASE_LO]];
    assign index0  = areg_i[{`IDX_PAD, field0[`IDX_HI:`IDX_LO]}];
    assign stack0  = areg_i[`SP_IDX];
    assign mag0    = {~|field0[`U8_HI:`U8_LO], field0[`U8_HI:`U8_LO]};
    assign mag13_0 = {~|field0[`N13_HI:`N13_LO], field0[`N13_HI:`N13_LO]};

    // Checks; they compare slot 0 results, and slot 1 in move_slot_a, against the request one cycle
    // earlier, because the snapshot may change once the answer is out.
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);

    rsp_follows_a: assert property (
        req_valid_i |=> rsp_valid_o && slot_valid_o[0])
        else $error("response strobe did not follow a request");

    move_slot_a: assert property (
        req_valid_i && !move_op_i |=> !slot_valid_o[1] && !wb_en_o[1])
        else $error("second slot active for a non-move request");

    ofs_byte_a: assert property (
        req_valid_i && field0[`TOP_HI:`TOP2_LO] == `CODE_OFS_B
        |=> eff_addr_o[0] == $past(base0)
            + 32'($past(field0[`U10_HI:`U10_LO]))
            && !wb_en_o[0])
        else $error("byte offset address wrong");

    ofs_word_a: assert property (
        req_valid_i && field0[`TOP_HI:`TOP2_LO] == `CODE_OFS_W
        |=> eff_addr_o[0] == $past(base0)
            + {20'h0, $past(field0[`U10_HI:`U10_LO]), 2'h0})
        else $error("word offset address wrong");

    post_index_a: assert property (
        req_valid_i && field0[`TOP_HI:`TOP3_LO] == `CODE_POST_IX
        && field0[`BASE_HI:`BASE_LO] != `SP_IDX
        |=> eff_addr_o[0] == $past(base0)
            + 32'($past(field0[`U7_HI:`U7_LO]))
            && wb_en_o[0] && wb_val_o[0] == $past(base0) + $past(index0))
        else $error("post index update wrong");

    stack_neg_a: assert property (
        req_valid_i && field0[`TOP_HI:`TOP3_LO] == `CODE_STK_NEG
        |=> eff_addr_o[0] == $past(stack0) - 32'($past(mag13_0))
            && !wb_en_o[0])
        else $error("stack relative address wrong");

    post_inc_a: assert property (
        req_valid_i && field0[`TOP_HI:`TOP4_LO] == `CODE_POST_IN
        |=> eff_addr_o[0] == $past(base0) && wb_en_o[0]
            && wb_val_o[0] == $past(base0)
            + 32'($past(field0[`U8_HI:`U8_LO])))
        else $error("post increment wrong");

    post_dec_a: assert property (
        req_valid_i && field0[`TOP_HI:`TOP4_LO] == `CODE_POST_DE
        && field0[`BASE_HI:`BASE_LO] != `SP_IDX
        |=> eff_addr_o[0] == $past(base0)
            && wb_val_o[0] == $past(base0) - 32'($past(mag0)))
        else $error("post decrement wrong");

    pre_dec_a: assert property (
        req_valid_i && field0[`TOP_HI:`TOP4_LO] == `CODE_PRE_DE
        |=> eff_addr_o[0] == wb_val_o[0]
            && wb_val_o[0] == $past(base0) - 32'($past(mag0)))
        else $error("pre decrement wrong");

    scaled_addr_a: assert property (
        req_valid_i && field0[`TOP_HI:`TOP4_LO] == `CODE_SCALED
        |=> eff_addr_o[0] == $past(base0)
            + ($past(index0) << $past(field0[`SH_HI:`SH_LO])))
        else $error("scaled index address wrong");

    dest_wb_a: assert property (
        req_valid_i && field0[`TOP_HI:`TOP4_LO] == `CODE_SCALED
        |=> wb_en_o[0] == ($past(field0[`DEST_HI:`DEST_LO]) != `NO_DEST)
            && wb_idx_o[0] == $past(field0[`DEST_HI:`DEST_LO])
            && wb_val_o[0] == eff_addr_o[0])
        else $error("destination write-back wrong");

    sp_invalid_a: assert property (
        req_valid_i && field0[`BASE_HI:`BASE_LO] == `SP_IDX
        && (field0[`TOP_HI:`TOP3_LO] == `CODE_POST_IX
            || field0[`TOP_HI:`TOP4_LO] == `CODE_POST_DE)
        |=> invalid_o[0] && !wb_en_o[0])
        else $error("unusable stack pointer mode not flagged");

    // Main scenarios worth seeing in simulation.
    move_pair_c: cover property (req_valid_i && move_op_i ##1 rsp_valid_o);
    zero_mag_c: cover property (
        req_valid_i && field0[`TOP_HI:`TOP4_LO] == `CODE_PRE_DE
        && field0[`U8_HI:`U8_LO] == 8'h0);
    scaled_wb_c: cover property (
        req_valid_i && field0[`TOP_HI:`TOP4_LO] == `CODE_SCALED
        && field0[`DEST_HI:`DEST_LO] != `NO_DEST);
    sp_reject_c: cover property (invalid_o[0]);

endmodule

// ### addr_map.svh
/*
 * Field positions, mode codes and fixed selectors of the 16-bit primary
 * memory-operand field. Included by every design file
 * that decodes the field; it holds definitions only.
 */
`ifndef ADDR_FIELD16_MAP_SVH
`define ADDR_FIELD16_MAP_SVH

// Position of the operand field inside a non-move instruction word.
`define FLD_INSTR_HI 31
`define FLD_INSTR_LO 16

// Mode prefix positions inside the field.
`define TOP_HI       15
`define TOP2_LO      14
`define TOP3_LO      13
`define TOP4_LO      12

// Sub-field positions inside the field.
`define BASE_HI      3
`define BASE_LO      0
`define IDX_HI       5
`define IDX_LO       4
`define DEST_HI      9
`define DEST_LO      6
`define SH_HI        11
`define SH_LO        10
`define U10_HI       13
`define U10_LO       4
`define U7_HI        12
`define U7_LO        6
`define N13_HI       12
`define N13_LO       0
`define U8_HI        11
`define U8_LO        4

// Mode prefix codes.
`define CODE_OFS_B   2'h0
`define CODE_OFS_W   2'h1
`define CODE_POST_IX 3'h4
`define CODE_STK_NEG 3'h5
`define CODE_POST_IN 4'hc
`define CODE_POST_DE 4'hd
`define CODE_PRE_DE  4'he
`define CODE_SCALED  4'hf

// Fixed selectors and shift of the word-stepped offset.
`define SP_IDX       4'hf
`define NO_DEST      4'hf
`define WORD_SHIFT   2
`define IDX_PAD      2'h0

`endif

// ### addr_field16_pkg.sv
/*
 * Types shared by the operand-field decoder files.
 * Assumes addr_map.svh is on the include path.
 */
package addr_field16_pkg;

    // Contents of the sixteen 32-bit address registers, entry 15 is the SP.
    typedef logic [15:0][31:0] areg_file_t;

    // Decoded addressing mode of one operand field.
    typedef enum logic [2:0]
    {
        MODE_OFS_B    = 3'h0,
        MODE_OFS_W    = 3'h1,
        MODE_POST_IDX = 3'h3,
        MODE_STK_NEG  = 3'h2,
        MODE_POST_INC = 3'h6,
        MODE_POST_DEC = 3'h7,
        MODE_PRE_DEC  = 3'h5,
        MODE_SCALED   = 3'h4
    } mode_t;

endpackage

// ### addr_gen_if.sv
/*
 * Carrier between the decoder top and one address generator: the field
 * and register snapshot going in, the address and write-back coming out.
 * Assumes addr_field16_pkg is compiled first.
 */
`timescale 1ns/10ps

interface addr_gen_if;
    logic [15:0]                field;
    addr_field16_pkg::areg_file_t regs;
    logic [31:0]                addr;
    logic                       wb_en;
    logic [3:0]                 wb_idx;
    logic [31:0]                wb_val;
    logic                       invalid;
    addr_field16_pkg::mode_t    mode;

    // The generator computes, the top supplies inputs and samples results.
    modport gen  (input field, regs,
                  output addr, wb_en, wb_idx, wb_val, invalid, mode);
    modport user (output field, regs,
                  input addr, wb_en, wb_idx, wb_val, invalid, mode);
endinterface

// ### addr_gen.sv
/*
 * Combinational address generator for one 16-bit operand field.
 * Assumes the register snapshot is stable for the cycle in which the
 * caller samples the result; it holds no state.
 */
`timescale 1ns/10ps
`include "addr_map.svh"

module addr_gen
(
    // Field in, address and write-back out.
    addr_gen_if.gen g
);
    logic [31:0] base;
    logic [31:0] index;
    logic [31:0] stack;
    logic [8:0]  mag8;
    logic [13:0] mag13;
    logic [31:0] scaled;

    // Operand selection; the index selector reaches only registers 0 to 3.
    assign base   = g.regs[g.field[`BASE_HI:`BASE_LO]];
    assign index  = g.regs[{`IDX_PAD, g.field[`IDX_HI:`IDX_LO]}];
    assign stack  = g.regs[`SP_IDX];

    // Zero encodes the largest magnitude, so no encoding is wasted.
    assign mag8   = {~|g.field[`U8_HI:`U8_LO], g.field[`U8_HI:`U8_LO]};
    assign mag13  = {~|g.field[`N13_HI:`N13_LO],
                     g.field[`N13_HI:`N13_LO]};
    assign scaled = index << g.field[`SH_HI:`SH_LO];

    // Mode decode by prefix length, longest prefixes last.
    always_comb
    begin
        if (g.field[`TOP_HI:`TOP2_LO] == `CODE_OFS_B)
            g.mode = addr_field16_pkg::MODE_OFS_B;
        else if (g.field[`TOP_HI:`TOP2_LO] == `CODE_OFS_W)
            g.mode = addr_field16_pkg::MODE_OFS_W;
        else if (g.field[`TOP_HI:`TOP3_LO] == `CODE_POST_IX)
            g.mode = addr_field16_pkg::MODE_POST_IDX;
        else if (g.field[`TOP_HI:`TOP3_LO] == `CODE_STK_NEG)
            g.mode = addr_field16_pkg::MODE_STK_NEG;
        else if (g.field[`TOP_HI:`TOP4_LO] == `CODE_POST_IN)
            g.mode = addr_field16_pkg::MODE_POST_INC;
        else if (g.field[`TOP_HI:`TOP4_LO] == `CODE_POST_DE)
            g.mode = addr_field16_pkg::MODE_POST_DEC;
        else if (g.field[`TOP_HI:`TOP4_LO] == `CODE_PRE_DE)
            g.mode = addr_field16_pkg::MODE_PRE_DEC;
        else
            g.mode = addr_field16_pkg::MODE_SCALED;
    end

    // Address and write-back; all sums wrap at 32 bits.
    always_comb
    begin
        g.addr    = base;
        g.wb_en   = 1'b0;
        g.wb_idx  = g.field[`BASE_HI:`BASE_LO];
        g.wb_val  = base;
        g.invalid = 1'b0;
        case (g.mode)
            addr_field16_pkg::MODE_OFS_B:
                g.addr = base + 32'(g.field[`U10_HI:`U10_LO]);
            addr_field16_pkg::MODE_OFS_W:
                g.addr = base + (32'(g.field[`U10_HI:`U10_LO])
                         << `WORD_SHIFT);
            addr_field16_pkg::MODE_POST_IDX:
            begin
                g.addr    = base + 32'(g.field[`U7_HI:`U7_LO]);
                g.wb_val  = base + index;
                g.invalid = (g.field[`BASE_HI:`BASE_LO] == `SP_IDX);
                g.wb_en   = !g.invalid;
            end
            addr_field16_pkg::MODE_STK_NEG:
            begin
                g.addr    = stack - 32'(mag13);
                g.wb_idx  = `SP_IDX;
            end
            addr_field16_pkg::MODE_POST_INC:
            begin
                g.wb_val  = base + 32'(g.field[`U8_HI:`U8_LO]);
                g.wb_en   = 1'b1;
            end
            addr_field16_pkg::MODE_POST_DEC:
            begin
                g.wb_val  = base - 32'(mag8);
                g.invalid = (g.field[`BASE_HI:`BASE_LO] == `SP_IDX);
                g.wb_en   = !g.invalid;
            end
            addr_field16_pkg::MODE_PRE_DEC:
            begin
                g.wb_val  = base - 32'(mag8);
                g.addr    = g.wb_val;
                g.wb_en   = 1'b1;
            end
            addr_field16_pkg::MODE_SCALED:
            begin
                g.addr    = base + scaled;
                g.wb_idx  = g.field[`DEST_HI:`DEST_LO];
                g.wb_val  = g.addr;
                g.wb_en   = (g.field[`DEST_HI:`DEST_LO] != `NO_DEST);
            end
            default:
                g.addr    = base;
        endcase
    end

endmodule

// ### areg_model.sv
/*
 * Behavioural model of the pipeline's address register file.
 * Assumes it shares the decoder's clock and reset and that the decoder
 * answers one cycle after each request.
 */
`timescale 1ns/10ps

module areg_model
(
    // Clock and reset.
    input  wire logic                         mclk_i,
    input  wire logic                         rst_b_i,
    // Write-back from the decoder.
    input  wire logic                         rsp_valid_i,
    input  wire logic [1:0]                   wb_en_i,
    input  wire logic [1:0][3:0]              wb_idx_i,
    input  wire logic [1:0][31:0]             wb_val_i,
    // Register snapshot to the decoder.
    output addr_field16_pkg::areg_file_t      areg_o
);
    // Seeds each register with a distinct pattern so a wrong selector
    // shows up; entry 0 is small so that decrements wrap below zero.
    // Slot 1 is written last, so it wins when both name one register.
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (int i = 0; i < 16; i++)
                areg_o[i] <= {4'(i), 20'h00000, 4'h8, 4'(i)};
        end
        else if (rsp_valid_i)
        begin
            for (int k = 0; k < 2; k++)
                if (wb_en_i[k])
                    areg_o[wb_idx_i[k]] <= wb_val_i[k];
        end
    end
endmodule

// ### test_addr_field16_decoder.sv
/*
 * Self-checking testbench of the operand-field decoder.
 * Assumes the package, carrier, generator, decoder and areg_model are
 * compiled before it.
 */
`timescale 1ns/10ps

module test_addr_field16_decoder;
    typedef struct packed
    {
        logic [31:0] addr;
        logic        en;
        logic [3:0]  idx;
        logic [31:0] val;
        logic        inv;
    } exp_t;

    logic                         mclk_i = 1'b0;
    logic                         rst_b_i = 1'b0;
    logic                         req_valid_i = 1'b0;
    logic [31:0]                  instr_word_i = 32'h00000000;
    logic                         move_op_i = 1'b0;
    logic [15:0]                  move_field_i = 16'h0000;
    addr_field16_pkg::areg_file_t areg;
    logic                         rsp_valid_o;
    logic [1:0]                   slot_valid_o;
    logic [1:0][31:0]             eff_addr_o;
    logic [1:0]                   wb_en_o;
    logic [1:0][3:0]              wb_idx_o;
    logic [1:0][31:0]             wb_val_o;
    logic [1:0]                   invalid_o;
    int                           err_count = 0;
    int                           n_tests = 0;

    addr_field16_decoder uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .req_valid_i(req_valid_i), .instr_word_i(instr_word_i),
        .move_op_i(move_op_i), .move_field_i(move_field_i), .areg_i(areg),
        .rsp_valid_o(rsp_valid_o), .slot_valid_o(slot_valid_o),
        .eff_addr_o(eff_addr_o), .wb_en_o(wb_en_o), .wb_idx_o(wb_idx_o),
        .wb_val_o(wb_val_o), .invalid_o(invalid_o));

    areg_model partner (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .rsp_valid_i(rsp_valid_o), .wb_en_i(wb_en_o), .wb_idx_i(wb_idx_o),
        .wb_val_i(wb_val_o), .areg_o(areg));

    // 50 MHz clock.
    always #10 mclk_i = ~mclk_i;

    // Reports a mismatch at once and counts every comparison.
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
            err_count++;
        end
    endtask

    // Expected result of one field, worked out from the mode encodings.
    function automatic exp_t calc(input logic [15:0] f,
                                  input addr_field16_pkg::areg_file_t r);
        exp_t        e;
        logic [31:0] b;
        logic [31:0] n8;
        logic [31:0] n13;
        b = r[f[3:0]];
        n8 = (f[11:4] == 8'h00) ? 32'h100 : {24'h0, f[11:4]};
        n13 = (f[12:0] == 13'h0) ? 32'h2000 : {19'h0, f[12:0]};
        e = '0;
        e.idx = f[3:0];
        e.en = 1'b1;
        e.inv = (f[3:0] == 4'hf) && (f[15:13] == 3'h4 || f[15:12] == 4'hd);
        casez (f[15:12])
            4'b00??: e.addr = b + {22'h0, f[13:4]};
            4'b01??: e.addr = b + {20'h0, f[13:4], 2'h0};
            4'b100?: e.addr = b + {25'h0, f[12:6]};
            4'b101?: e.addr = r[15] - n13;
            4'hc:    e.addr = b;
            4'hd:    e.addr = b;
            4'he:    e.addr = b - n8;
            default: e.addr = b + (r[{2'h0, f[5:4]}] << f[11:10]);
        endcase
        casez (f[15:12])
            4'b100?: e.val = b + r[{2'h0, f[5:4]}];
            4'hc:    e.val = b + {24'h0, f[11:4]};
            4'hd:    e.val = b - n8;
            default: e.val = e.addr;
        endcase
        if (f[15:12] == 4'hf)
            e.idx = f[9:6];
        if (f[15:14] != 2'h2 && f[15:12] < 4'hc || f[15:13] == 3'h5)
            e.en = 1'b0;
        if (f[15:12] == 4'hf && f[9:6] == 4'hf || e.inv)
            e.en = 1'b0;
        return e;
    endfunction

    // One isolated request; the snapshot is read where the decoder
    // samples it, and results are judged half a cycle after that edge.
    task automatic do_req(input logic [15:0] f0, input logic mv,
                          input logic [15:0] f1);
        exp_t e [2];
        @(posedge mclk_i);
        req_valid_i <= 1'b1;
        instr_word_i <= {f0, 16'h5a5a};
        move_op_i <= mv;
        move_field_i <= f1;
        @(negedge mclk_i);
        e[0] = calc(f0, areg);
        e[1] = calc(f1, areg);
        e[1].en = e[1].en & mv;
        e[1].inv = e[1].inv & mv;
        @(posedge mclk_i);
        req_valid_i <= 1'b0;
        @(negedge mclk_i);
        chk("rsp_valid", 32'(rsp_valid_o), 32'h1);
        chk("slot_valid", 32'(slot_valid_o), {30'h0, mv, 1'b1});
        for (int k = 0; k < 2; k++)
        begin
            if (k == 0 || mv)
                chk("eff_addr", eff_addr_o[k], e[k].addr);
            chk("wb_en", 32'(wb_en_o[k]), 32'(e[k].en));
            chk("invalid", 32'(invalid_o[k]), 32'(e[k].inv));
            if (e[k].en)
            begin
                chk("wb_idx", 32'(wb_idx_o[k]), 32'(e[k].idx));
                chk("wb_val", wb_val_o[k], e[k].val);
            end
        end
    endtask

    task automatic t_offset();
        do_req(16'h0015, 1'b0, 16'hffff);
        do_req({2'h0, 10'h3ff, 4'h7}, 1'b0, 16'h0000);
        do_req({2'h1, 10'h3ff, 4'h2}, 1'b0, 16'h0000);
        do_req({2'h1, 10'h001, 4'hf}, 1'b0, 16'h0000);
    endtask

    task automatic t_post_idx();
        do_req({3'h4, 7'h7f, 2'h3, 4'h1}, 1'b0, 16'h0);
        do_req({3'h4, 7'h00, 2'h2, 4'he}, 1'b0, 16'h0);
    endtask

    task automatic t_stack();
        do_req({3'h5, 13'h0001}, 1'b0, 16'h0);
        do_req({3'h5, 13'h0000}, 1'b0, 16'h0);
        do_req({3'h5, 13'h1fff}, 1'b0, 16'h0);
    endtask

    task automatic t_inc_dec();
        do_req({4'hc, 8'hff, 4'h3}, 1'b0, 16'h0);
        do_req({4'hc, 8'h00, 4'hf}, 1'b0, 16'h0);
        do_req({4'hd, 8'h01, 4'h4}, 1'b0, 16'h0);
        do_req({4'hd, 8'h00, 4'h0}, 1'b0, 16'h0);
        do_req({4'he, 8'h00, 4'h0}, 1'b0, 16'h0);
        do_req({4'he, 8'h80, 4'hf}, 1'b0, 16'h0);
    endtask

    // Every shift amount, then a destination write-back.
    task automatic t_scaled();
        for (int s = 0; s < 4; s++)
            do_req({4'hf, 2'(s), 4'hf, 2'(s), 4'h9}, 1'b0, 16'h0);
        do_req({4'hf, 2'h3, 4'h6, 2'h1, 4'hf}, 1'b0, 16'h0);
    endtask

    task automatic t_sp_bad();
        do_req({3'h4, 7'h01, 2'h1, 4'hf}, 1'b0, 16'h0);
        do_req({4'hd, 8'h10, 4'hf}, 1'b0, 16'h0);
    endtask

    // Both slots name the same register, and a move with a stack slot.
    task automatic t_move();
        do_req({4'hc, 8'h04, 4'h2}, 1'b1, {4'he, 8'h08, 4'h2});
        do_req(16'h0015, 1'b1, {3'h5, 13'h0010});
        do_req({3'h4, 7'h05, 2'h0, 4'hf}, 1'b1,
               {3'h4, 7'h05, 2'h0, 4'h1});
    endtask

    // The answer stands one cycle only.
    task automatic t_idle();
        do_req(16'h0015, 1'b1, 16'h0015);
        @(negedge mclk_i);
        chk("rsp_valid", 32'(rsp_valid_o), 32'h0);
        chk("slot_valid", 32'(slot_valid_o), 32'h0);
    endtask

    task automatic end_of_test();
        if (err_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Main sequence; rsp_valid_o is checked quiet while reset is held.
    initial
    begin
        repeat (16) @(posedge mclk_i);
        chk("rsp_valid", 32'(rsp_valid_o), 32'h0);
        rst_b_i <= 1'b1;
        t_offset();
        t_post_idx();
        t_stack();
        t_inc_dec();
        t_scaled();
        t_sp_bad();
        t_move();
        t_idle();
        end_of_test();
    end

    // Watchdog, far beyond the seventy or so cycles the tests need.
    initial
    begin
        #200000;
        err_count++;
        end_of_test();
    end
endmodule
